/* logic/srq_pkg.sv */
// ****************************************************************
// status reporting constants
// ****************************************************************
package srq_pkg;

  // register word offsets, byte addresses on the plain port
  localparam logic [7:0] SRQ_ADDR_CMD = 8'h00; // command strobes
  localparam logic [7:0] SRQ_ADDR_ESE = 8'h04; // event enable mask
  localparam logic [7:0] SRQ_ADDR_ESR = 8'h08; // event status
  localparam logic [7:0] SRQ_ADDR_SRE = 8'h0c; // status byte mask
  localparam logic [7:0] SRQ_ADDR_STB = 8'h10; // status byte
  localparam logic [7:0] SRQ_ADDR_OUTQ = 8'h14; // output queue pop
  localparam logic [7:0] SRQ_ADDR_IST = 8'h18; // irq status, w1c
  localparam logic [7:0] SRQ_ADDR_IMSK = 8'h1c; // irq mask
  localparam logic [7:0] SRQ_ADDR_BUSY = 8'h20; // flush in progress

  // command register bit positions
  localparam int SRQ_CMD_CLS = 0; // clear status
  localparam int SRQ_CMD_OPC = 1; // operation complete command
  localparam int SRQ_CMD_OPCQ = 2; // operation complete query

  // event status bit positions
  localparam int SRQ_ESR_OPC = 0;
  localparam int SRQ_ESR_UNUSED1 = 1;
  localparam int SRQ_ESR_QRY = 2;
  localparam int SRQ_ESR_DEV = 3;
  localparam int SRQ_ESR_EXE = 4;
  localparam int SRQ_ESR_CMD = 5;
  localparam int SRQ_ESR_UNUSED6 = 6;
  localparam int SRQ_ESR_PON = 7;

  // status byte bit positions
  localparam int SRQ_STB_MAV = 4; // reply waiting
  localparam int SRQ_STB_ESB = 5; // event summary
  localparam int SRQ_STB_RQS = 6; // request summary

  // irq status bit positions
  localparam int SRQ_IRQ_ESR = 0; // event status bit newly set
  localparam int SRQ_IRQ_REPLY = 1; // reply placed in queue
  localparam int SRQ_IRQ_FLUSHED = 2; // queue flush finished
  localparam int SRQ_IRQ_W = 3;

  // reset values
  localparam logic [7:0] SRQ_RST_ESR = 8'h80; // power-on bit set
  localparam logic [7:0] SRQ_RST_MASK = 8'h00; // all masks cleared
  localparam logic [7:0] SRQ_OPC_REPLY = 8'h01; // answer to query

  // timing
  localparam int SRQ_CLK_MHZ = 200;
  localparam int SRQ_FLUSH_TIME_MS = 300; // 0.3 s queue clear
  localparam int SRQ_FLUSH_CYC = SRQ_FLUSH_TIME_MS * 1000 * SRQ_CLK_MHZ;

  // queue flush state
  typedef enum logic [0:0] {
    SRQ_IDLE = 1'b0,
    SRQ_FLUSH = 1'b1
  } srq_mode_t;

endpackage

/* logic/srq_sticky.sv */
`timescale 1ns/1ps
// ****************************************************************
// sticky bit register, set wins over clear
// ****************************************************************
module srq_sticky #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);

  // state of the register
  typedef struct packed {
    logic [W-1:0] val; // held bits
  } srq_stk_t;

  srq_stk_t st;
  srq_stk_t next_st;

  // clear first, then set so a same-cycle event survives
  always_comb begin
    next_st = st;
    next_st.val = (st.val & ~clr_i) | set_i;
  end

  // registered state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st.val <= RST;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.val;

endmodule

/* logic/srq_status.sv */
`timescale 1ns/1ps
module srq_status
  import srq_pkg::*;
#(
  parameter int FLUSH_CYC = SRQ_FLUSH_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic pending_i,
  input wire logic err_query_i,
  input wire logic err_dev_i,
  input wire logic err_exec_i,
  input wire logic err_cmd_i,
  input wire logic [7:0] stb_aux_i,
  output logic srq_o,
  output logic irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam int CNT_W = $clog2(FLUSH_CYC + 1);
  localparam logic [CNT_W-1:0] FLUSH_LAST = CNT_W'(FLUSH_CYC - 1);

  typedef struct packed {
    logic [7:0] ese; // event enable mask
    logic [7:0] sre; // status byte mask
    logic [SRQ_IRQ_W-1:0] imask; // irq mask
    logic opc_arm; // waiting to set complete bit
    logic qry_arm; // waiting to queue the reply
    logic q_full; // output queue holds a reply
    logic [7:0] q_data; // queued reply
    srq_mode_t mode; // queue flush state
    logic [CNT_W-1:0] cnt; // flush cycle counter
    logic [7:0] rdata; // read data, one cycle late
    logic srq; // service request
    logic irq; // interrupt line
  } srq_state_t;

  srq_state_t st;
  srq_state_t next_st;

  logic wr_cmd; // command register written
  logic cls; // clear status strobe
  logic [7:0] esr; // event status value
  logic [7:0] esr_set; // event status set vector
  logic [7:0] esr_clr; // event status clear vector
  logic [7:0] stb; // assembled status byte
  logic srq_req; // any enabled status byte bit other than RQS
  logic opc_fire; // complete bit set this cycle
  logic push; // reply enters queue this cycle
  logic flush_done; // flush ends this cycle
  logic [SRQ_IRQ_W-1:0] ist; // irq status
  logic [SRQ_IRQ_W-1:0] ist_set; // irq events
  logic [SRQ_IRQ_W-1:0] ist_clr; // irq w1c clear

  // ****************************************************************
  // event and status assembly
  // ****************************************************************

  // decode of command strobes
  assign wr_cmd = wr_i && (addr_i == SRQ_ADDR_CMD);
  assign cls = wr_cmd && wdata_i[SRQ_CMD_CLS];

  // complete bit once every pending operation finished
  assign opc_fire = st.opc_arm && !pending_i;

  // reply only when idle, queue free and not flushing
  assign push = st.qry_arm && !pending_i && !st.q_full
    && (st.mode == SRQ_IDLE);

  assign flush_done = (st.mode == SRQ_FLUSH) && (st.cnt == '0);

  // event bits, unused positions never set
  always_comb begin
    esr_set = 8'h00;
    esr_set[SRQ_ESR_OPC] = opc_fire;
    esr_set[SRQ_ESR_QRY] = err_query_i;
    esr_set[SRQ_ESR_DEV] = err_dev_i;
    esr_set[SRQ_ESR_EXE] = err_exec_i;
    esr_set[SRQ_ESR_CMD] = err_cmd_i;
  end

  // clear status wipes every event bit not set again in the same cycle
  assign esr_clr = {8{cls}};

  srq_sticky #(
    .W(8),
    .RST(SRQ_RST_ESR)
  ) u_esr (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .set_i(esr_set),
    .clr_i(esr_clr),
    .q_o(esr)
  );

  // status byte: aux bits, reply waiting, summary, request
  always_comb begin
    stb = stb_aux_i;
    stb[SRQ_STB_MAV] = st.q_full;
    stb[SRQ_STB_ESB] = |(esr & st.ese);
    stb[SRQ_STB_RQS] = st.srq;
  end

  // request while any enabled byte bit other than RQS is set
  always_comb begin
    srq_req = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i != SRQ_STB_RQS) begin
        srq_req = srq_req | (stb[i] & st.sre[i]);
      end
    end
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************

  // events for software: new event bit, reply, flush end
  always_comb begin
    ist_set = '0;
    ist_set[SRQ_IRQ_ESR] = |(esr_set & ~esr);
    ist_set[SRQ_IRQ_REPLY] = push;
    ist_set[SRQ_IRQ_FLUSHED] = flush_done;
  end

  // write one to clear
  assign ist_clr = (wr_i && (addr_i == SRQ_ADDR_IST))
    ? wdata_i[SRQ_IRQ_W-1:0] : '0;

  srq_sticky #(
    .W(SRQ_IRQ_W),
    .RST('0)
  ) u_ist (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .set_i(ist_set),
    .clr_i(ist_clr),
    .q_o(ist)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.srq = srq_req;
    next_st.irq = |(ist & st.imask);

    // mask writes
    if (wr_i) begin
      case (addr_i)
        SRQ_ADDR_ESE: begin
          next_st.ese = wdata_i[7:0];
        end
        SRQ_ADDR_SRE: begin
          next_st.sre = wdata_i[7:0];
        end
        SRQ_ADDR_IMSK: begin
          next_st.imask = wdata_i[SRQ_IRQ_W-1:0];
        end
        default: begin
          next_st.imask = st.imask;
        end
      endcase
    end

    // operation complete handling
    if (opc_fire) begin
      next_st.opc_arm = 1'b0;
    end
    if (push) begin
      next_st.qry_arm = 1'b0;
      next_st.q_full = 1'b1;
      next_st.q_data = SRQ_OPC_REPLY;
    end
    if (wr_cmd && wdata_i[SRQ_CMD_OPC]) begin
      next_st.opc_arm = 1'b1;
    end
    if (wr_cmd && wdata_i[SRQ_CMD_OPCQ]) begin
      next_st.qry_arm = 1'b1;
    end

    // reads, data stands one cycle later
    if (rd_i) begin
      case (addr_i)
        SRQ_ADDR_ESE: begin
          next_st.rdata = st.ese;
        end
        SRQ_ADDR_ESR: begin
          next_st.rdata = esr;
        end
        SRQ_ADDR_SRE: begin
          next_st.rdata = st.sre;
        end
        SRQ_ADDR_STB: begin
          next_st.rdata = stb;
        end
        SRQ_ADDR_OUTQ: begin
          // pop the reply, empty queue reads zero
          if (st.q_full && !push) begin
            next_st.rdata = st.q_data;
            next_st.q_full = 1'b0;
          end
        end
        SRQ_ADDR_IST: begin
          next_st.rdata = 8'(ist);
        end
        SRQ_ADDR_IMSK: begin
          next_st.rdata = 8'(st.imask);
        end
        SRQ_ADDR_BUSY: begin
          next_st.rdata = {7'h00, st.mode == SRQ_FLUSH};
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    // queue flush timing
    case (st.mode)
      SRQ_IDLE: begin
        next_st.cnt = '0;
      end
      SRQ_FLUSH: begin
        next_st.q_full = 1'b0;
        if (st.cnt == '0) begin
          next_st.mode = SRQ_IDLE;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      default: begin
        next_st.mode = SRQ_IDLE;
      end
    endcase

    // clear status: queue emptied, waits reloaded from the same write, masks kept
    if (cls) begin
      next_st.q_full = 1'b0;
      next_st.mode = SRQ_FLUSH;
      next_st.cnt = FLUSH_LAST;
      next_st.opc_arm = wdata_i[SRQ_CMD_OPC];
      next_st.qry_arm = wdata_i[SRQ_CMD_OPCQ];
      next_st.ese = st.ese;
      next_st.sre = st.sre;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st.ese <= SRQ_RST_MASK;
      st.sre <= SRQ_RST_MASK;
      st.imask <= '0;
      st.opc_arm <= 1'b0;
      st.qry_arm <= 1'b0;
      st.q_full <= 1'b0;
      st.q_data <= 8'h00;
      st.mode <= SRQ_IDLE;
      st.cnt <= '0;
      st.rdata <= 8'h00;
      st.srq <= 1'b0;
      st.irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = {24'h000000, st.rdata};
  assign srq_o = st.srq;
  assign irq_o = st.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_cls_zeroes: assert property (
    cls && (esr_set == 8'h00) |=> esr == 8'h00)
    else $error("event status not zero after clear");

  a_cls_masks: assert property (
    cls |=> (st.ese == $past(st.ese)) && (st.sre == $past(st.sre)))
    else $error("clear status changed a mask");

  a_flush_queue: assert property (
    cls |=> (st.mode == SRQ_FLUSH) && !st.q_full
      && (st.cnt == FLUSH_LAST))
    else $error("clear status did not start queue flush");

  a_ese_load: assert property (
    wr_i && (addr_i == SRQ_ADDR_ESE) |=> st.ese == $past(wdata_i[7:0]))
    else $error("event enable mask not loaded");

  a_ese_read: assert property (
    rd_i && (addr_i == SRQ_ADDR_ESE) |=> rdata_o == {24'h0, $past(st.ese)})
    else $error("event enable readback wrong");

  a_esr_read: assert property (
    rd_i && (addr_i == SRQ_ADDR_ESR) |=> rdata_o == {24'h0, $past(esr)})
    else $error("event status readback wrong");

  a_opc_sets: assert property (
    st.opc_arm && !pending_i |=> esr[SRQ_ESR_OPC]
      && (!st.opc_arm || $past(wr_cmd && wdata_i[SRQ_CMD_OPC])))
    else $error("complete bit not set when idle");

  a_reply_waits: assert property (
    st.qry_arm && pending_i && !st.q_full |=> !st.q_full)
    else $error("reply queued while busy");

  a_sre_load: assert property (
    wr_i && (addr_i == SRQ_ADDR_SRE) |=> st.sre == $past(wdata_i[7:0]))
    else $error("status byte mask not loaded");

  a_unused_bits: assert property (
    !esr[SRQ_ESR_UNUSED1] && !esr[SRQ_ESR_UNUSED6])
    else $error("unused event bit set");

  a_srq_level: assert property (
    st.sre[SRQ_STB_ESB] && |(esr & st.ese) |=> srq_o)
    else $error("service request level wrong");

  c_srq_from_esr: cover property (
    st.sre[SRQ_STB_ESB] && stb[SRQ_STB_ESB] ##1 srq_o);
  c_opc_query: cover property (st.qry_arm && pending_i ##[1:20] push);
  c_flush_end: cover property (flush_done);
  c_irq: cover property (irq_o);

endmodule

/* test/srq_ctl.sv */
`timescale 1ns/1ps
// ****************************************
// remote controller on the register port
// ****************************************
module srq_ctl
  import srq_pkg::*;
(
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // idle bus at time zero
  initial begin
    addr_o = 8'hff;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // one-cycle write, lines scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= {24'h000000, d};
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~{24'h000000, d};
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask

  // route event summary into the request
  task automatic arm();
    wr(SRQ_ADDR_SRE, 8'h20);
  endtask

  // answer a request: status byte first, then clear
  task automatic serve(output logic [31:0] stb);
    rd(SRQ_ADDR_STB, stb);
    wr(SRQ_ADDR_CMD, 8'h01);
  endtask
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
// compare and count, report at once
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("wrong value at %0t: got %h want %h", $time, g, e); \
    end \
  end
module tb
  import srq_pkg::*;
;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk;
  logic rst_b;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic pending;
  logic [3:0] err; // query, device, exec, command
  logic [7:0] aux;
  logic srq;
  logic irq;
  logic [31:0] d;
  int bad_count;
  int n_tests;

  srq_status #(.FLUSH_CYC(16)) i_srq_status (
    .clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pending_i(pending),
    .err_query_i(err[0]), .err_dev_i(err[1]), .err_exec_i(err[2]),
    .err_cmd_i(err[3]), .stb_aux_i(aux), .srq_o(srq), .irq_o(irq)
  );

  srq_ctl i_srq_ctl (
    .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd)
  );

  // free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic test_done();
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // power-on bit up, event enable mask clear, no request
  task automatic t_reset();
    i_srq_ctl.rd(SRQ_ADDR_ESR, d);
    `CHK(d, 32'h80)
    i_srq_ctl.rd(SRQ_ADDR_ESE, d);
    `CHK(d, 32'h0)
    `CHK(srq, 1'b0)
  endtask

  // each weight selects one bit, sums read back whole
  task automatic t_masks();
    for (int i = 0; i < 8; i++) begin
      i_srq_ctl.wr(SRQ_ADDR_ESE, 8'h01 << i);
      i_srq_ctl.rd(SRQ_ADDR_ESE, d);
      `CHK(d, 32'h1 << i)
      i_srq_ctl.wr(SRQ_ADDR_SRE, 8'h01 << i);
      i_srq_ctl.rd(SRQ_ADDR_SRE, d);
      `CHK(d, 32'h1 << i)
    end
    i_srq_ctl.wr(SRQ_ADDR_ESE, 8'hff);
    i_srq_ctl.rd(SRQ_ADDR_ESE, d);
    `CHK(d, 32'hff)
    i_srq_ctl.wr(SRQ_ADDR_ESE, 8'h35);
    i_srq_ctl.rd(SRQ_ADDR_ESE, d);
    `CHK(d, 32'h35)
    i_srq_ctl.wr(SRQ_ADDR_ESE, 8'h00);
    i_srq_ctl.wr(SRQ_ADDR_SRE, 8'h00);
  endtask

  // error events, request and interrupt paths
  task automatic t_events();
    logic [31:0] e;
    e = 32'h80;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      err <= 4'h1 << i;
      @(posedge clk);
      err <= 4'h0;
      e = e | (32'h4 << i);
      i_srq_ctl.rd(SRQ_ADDR_ESR, d);
      `CHK(d, e)
      `CHK(srq, 1'b0)
    end
    i_srq_ctl.wr(SRQ_ADDR_ESE, 8'h10);
    i_srq_ctl.arm();
    cyc(3);
    `CHK(srq, 1'b1)
    i_srq_ctl.rd(SRQ_ADDR_STB, d);
    `CHK(d, 32'he1)
    i_srq_ctl.wr(SRQ_ADDR_IMSK, 8'h01);
    cyc(3);
    `CHK(irq, 1'b1)
    i_srq_ctl.wr(SRQ_ADDR_IMSK, 8'h00);
    cyc(3);
    `CHK(irq, 1'b0)
    i_srq_ctl.wr(SRQ_ADDR_IMSK, 8'h01);
    i_srq_ctl.wr(SRQ_ADDR_IST, 8'h01);
    cyc(3);
    `CHK(irq, 1'b0)
  endtask

  // clear status: values zero, masks kept, queue flush
  task automatic t_clear();
    int k;
    i_srq_ctl.serve(d);
    `CHK(d[6], 1'b1)
    i_srq_ctl.rd(SRQ_ADDR_ESR, d);
    `CHK(d, 32'h0)
    i_srq_ctl.rd(SRQ_ADDR_ESE, d);
    `CHK(d, 32'h10)
    i_srq_ctl.rd(SRQ_ADDR_SRE, d);
    `CHK(d, 32'h20)
    `CHK(srq, 1'b0)
    k = 0;
    d = 32'h1;
    while (d[0] === 1'b1 && k < 40) begin
      i_srq_ctl.rd(SRQ_ADDR_BUSY, d);
      k++;
    end
    if (k >= 40) begin
      bad_count++;
      test_done();
    end
    `CHK(k > 4, 1'b1)
    i_srq_ctl.rd(SRQ_ADDR_IST, d);
    `CHK(d[2], 1'b1)
  endtask

  // completion waits for pending work, read-only and holes
  task automatic t_opc();
    @(posedge clk);
    pending <= 1'b1;
    i_srq_ctl.wr(SRQ_ADDR_CMD, 8'h02);
    cyc(5);
    i_srq_ctl.rd(SRQ_ADDR_ESR, d);
    `CHK(d, 32'h0)
    @(posedge clk);
    pending <= 1'b0;
    cyc(3);
    i_srq_ctl.wr(SRQ_ADDR_ESR, 8'hff);
    i_srq_ctl.rd(SRQ_ADDR_ESR, d);
    `CHK(d, 32'h1)
    @(posedge clk);
    pending <= 1'b1;
    i_srq_ctl.wr(SRQ_ADDR_CMD, 8'h04);
    cyc(5);
    i_srq_ctl.rd(SRQ_ADDR_OUTQ, d);
    `CHK(d, 32'h0)
    @(posedge clk);
    pending <= 1'b0;
    cyc(3);
    // reply waiting shows in status byte and irq status
    i_srq_ctl.rd(SRQ_ADDR_STB, d);
    `CHK(d[4], 1'b1)
    i_srq_ctl.rd(SRQ_ADDR_IST, d);
    `CHK(d[1], 1'b1)
    i_srq_ctl.rd(SRQ_ADDR_OUTQ, d);
    `CHK(d, {24'h0, SRQ_OPC_REPLY})
    i_srq_ctl.rd(SRQ_ADDR_OUTQ, d);
    `CHK(d, 32'h0)
    i_srq_ctl.rd(8'h40, d);
    `CHK(d, 32'h0)
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    bad_count = 0;
    n_tests = 0;
    rst_b = 1'b0;
    pending = 1'b0;
    err = 4'h0;
    aux = 8'h81;
    cyc(16);
    rst_b <= 1'b1;
    t_reset();
    t_masks();
    t_events();
    t_clear();
    t_opc();
    test_done();
  end
endmodule
